// File: rtl/cfm_defines.svh
/*
 Constants for the CAN transceiver fault monitor: register addresses,
 field positions, reset values and timing figures.
 Assumes inclusion by bare name from rtl/.
*/
`ifndef CFM_DEFINES_SVH
`define CFM_DEFINES_SVH

// ==========================================================
// Register addresses (3-bit address field of a serial byte)
`define CFM_ADDR_MODE_CTRL 3'h0
`define CFM_ADDR_CAN_STATUS 3'h1
`define CFM_ADDR_IO_STATUS 3'h2
`define CFM_ADDR_INT_ENABLE 3'h3
`define CFM_ADDR_INT_STATUS 3'h4
`define CFM_ADDR_INT_MASK 3'h5
`define CFM_ADDR_CAN_CTRL 3'h6

// ==========================================================
// Serial byte layout
`define CFM_BYTE_ADDR_MSB 7
`define CFM_BYTE_ADDR_LSB 5
`define CFM_BYTE_RW_BIT 4
`define CFM_BYTE_DATA_MSB 3

// ==========================================================
// CAN status fields
`define CFM_CAN_WAKE_BIT 0
`define CFM_CAN_OVERCUR_BIT 1
`define CFM_CAN_TXSTUCK_BIT 2
`define CFM_CAN_OVERTEMP_BIT 3

// Mode control fields
`define CFM_MODE_GLOBAL_FAILURE_FLAG_BIT 3
`define CFM_MODE_CAN_NORMAL_BIT 0

// IO status fields
`define CFM_IO_SUPPLY_LOW_BIT 2

// Interrupt enable fields
`define CFM_IE_CAN_FAIL_BIT 0
`define CFM_IE_SUPPLY_LOW_BIT 1
`define CFM_IE_SWITCH_OT_BIT 2
`define CFM_IE_MAIN_LOW_BIT 3

// ==========================================================
// Reset values
`define CFM_INT_ENABLE_RST 4'h0
`define CFM_INT_MASK_RST 4'h0
`define CFM_CAN_CTRL_RST 1'b0

// ==========================================================
// Timing
`define CFM_CLK_MHZ 250
`define CFM_TX_STUCK_US 360

`endif

// File: rtl/cfm_pkg.sv
/*
 Types for the CAN transceiver fault monitor.
 Assumes nothing of its surroundings.
*/
package cfm_pkg;
  typedef logic [3:0] cfm_nib_t;
  typedef enum logic [2:0] {
    CFM_SH_IDLE = 3'b001,
    CFM_SH_SHIFT = 3'b010,
    CFM_SH_DONE = 3'b100
  } cfm_shift_e;
endpackage

// File: rtl/cfm_fault_monitor.sv
/*
 CAN transceiver fault monitor: supply, transmit-stuck, driver thermal and
 overcurrent faults with latched flags, driver disable (not on overcurrent), global failure,
 selectable interrupts, and a serial byte register port.
 Assumes synchronous inputs on core_clk; analog comparators are outside.
*/
`timescale 1ns/1ps
`include "cfm_defines.svh"

module cfm_fault_monitor
  import cfm_pkg::*;
#(
  parameter int CLK_MHZ = `CFM_CLK_MHZ,
  parameter int TX_STUCK_US = `CFM_TX_STUCK_US,
  parameter int TX_STUCK_CYC = TX_STUCK_US * CLK_MHZ
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [3:0] reg_rdata,
  // Serial byte port
  input wire logic spi_sel,
  input wire logic spi_sclk_rise,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Analog and pin conditions
  input wire logic ballast_used,
  input wire logic secondary_supply_below,
  input wire logic primary_supply_uv,
  input wire logic tx_data,
  input wire logic driver_overtemp,
  input wire logic driver_overcurrent,
  input wire logic bus_wakeup_event,
  input wire logic switch_overtemp,
  input wire logic main_supply_input_low,
  // Outputs
  output logic can_driver_en,
  output logic reset_out,
  output logic irq
);

  initial
  begin
    if (CLK_MHZ < 1 || TX_STUCK_CYC < 2)
      $error("cfm_fault_monitor: unsupported timing parameters");
  end

  localparam int CW = $clog2(TX_STUCK_CYC + 1);
  localparam logic [CW-1:0] STUCK_LIM = CW'(TX_STUCK_CYC);

  // ==========================================================
  // Serial byte shifter
  cfm_shift_e sh_q, sh_d;
  logic [7:0] sh_byte_q;
  logic [2:0] sh_cnt_q;
  logic [3:0] sh_out_q;
  logic spi_miso_q;
  logic s_last;
  wire [7:0] s_next = {sh_byte_q[6:0], spi_mosi};
  assign s_last = (sh_q == CFM_SH_SHIFT) && spi_sclk_rise && (sh_cnt_q == 3'h7);

  always_comb
  begin
    sh_d = sh_q;
    unique case (sh_q)
      CFM_SH_IDLE: if (spi_sel) sh_d = CFM_SH_SHIFT;
      CFM_SH_SHIFT: if (!spi_sel) sh_d = CFM_SH_IDLE; else if (s_last) sh_d = CFM_SH_DONE;
      CFM_SH_DONE: if (!spi_sel) sh_d = CFM_SH_IDLE;
      default: sh_d = CFM_SH_IDLE;
    endcase
  end

  // Byte decoded on its eighth bit, MSB first
  wire s_go = s_last;
  wire [2:0] s_addr = s_next[`CFM_BYTE_ADDR_MSB:`CFM_BYTE_ADDR_LSB];
  wire s_wr = s_go && s_next[`CFM_BYTE_RW_BIT];
  wire s_rd = s_go && !s_next[`CFM_BYTE_RW_BIT];
  wire [3:0] s_data = s_next[`CFM_BYTE_DATA_MSB:0];

  // Merge both access paths; the plain port has priority
  wire acc_wr = reg_wr | (!reg_rd & s_wr);
  wire acc_rd = reg_rd | (!reg_wr & s_rd);
  wire [2:0] acc_addr = (reg_wr | reg_rd) ? reg_addr : s_addr;
  wire [3:0] acc_wdata = reg_wr ? reg_wdata : s_data;

  // ==========================================================
  // Fault detection
  logic [CW-1:0] stuck_cnt_q;
  logic tx_stuck_q;
  wire stuck_hit = !tx_data && (stuck_cnt_q == STUCK_LIM);
  wire stuck_now = !tx_data && (tx_stuck_q || stuck_hit);
  wire supply_low = ballast_used ? secondary_supply_below : primary_supply_uv;

  // ==========================================================
  // Registers
  cfm_nib_t can_stat_q, io_stat_q, int_en_q, int_stat_q, int_mask_q;
  logic global_failure_flag_q, can_normal_q, reset_q, drv_en_q, irq_q;
  cfm_nib_t rdata_q;

  wire rd_can = acc_rd && (acc_addr == `CFM_ADDR_CAN_STATUS);
  wire rd_io = acc_rd && (acc_addr == `CFM_ADDR_IO_STATUS);
  wire rd_mode = acc_rd && (acc_addr == `CFM_ADDR_MODE_CTRL);
  wire rd_int = acc_rd && (acc_addr == `CFM_ADDR_INT_STATUS);
  wire wr_ie = acc_wr && (acc_addr == `CFM_ADDR_INT_ENABLE);
  wire wr_mask = acc_wr && (acc_addr == `CFM_ADDR_INT_MASK);
  wire wr_ctrl = acc_wr && (acc_addr == `CFM_ADDR_CAN_CTRL);

  // Flag set wins over clear; a read clears only a gone fault
  wire [3:0] can_live;
  assign can_live[`CFM_CAN_WAKE_BIT] = bus_wakeup_event || !can_normal_q;
  assign can_live[`CFM_CAN_OVERCUR_BIT] = driver_overcurrent;
  assign can_live[`CFM_CAN_TXSTUCK_BIT] = stuck_now;
  assign can_live[`CFM_CAN_OVERTEMP_BIT] = driver_overtemp;
  wire [3:0] can_set;
  assign can_set[`CFM_CAN_WAKE_BIT] = bus_wakeup_event;
  assign can_set[`CFM_CAN_OVERCUR_BIT] = driver_overcurrent;
  assign can_set[`CFM_CAN_TXSTUCK_BIT] = stuck_now;
  assign can_set[`CFM_CAN_OVERTEMP_BIT] = driver_overtemp;
  wire [3:0] can_d = can_set | (can_stat_q & ~({4{rd_can}} & ~can_live));

  wire can_fail_ev = driver_overcurrent | stuck_now | driver_overtemp;
  wire [3:0] io_set = 4'(supply_low) << `CFM_IO_SUPPLY_LOW_BIT;
  wire [3:0] io_d = io_set | (io_stat_q & ~({4{rd_io}} & ~io_set));

  // Interrupt sources gated by the enable register
  wire [3:0] ev;
  assign ev[`CFM_IE_CAN_FAIL_BIT] = can_fail_ev;
  assign ev[`CFM_IE_SUPPLY_LOW_BIT] = supply_low;
  assign ev[`CFM_IE_SWITCH_OT_BIT] = switch_overtemp;
  assign ev[`CFM_IE_MAIN_LOW_BIT] = main_supply_input_low;
  wire [3:0] ev_en = ev & int_en_q;
  wire [3:0] ist_d = ev_en | (int_stat_q & ~{4{rd_int}});

  // Global failure: set by any CAN fault, cleared by mode register read
  wire global_failure_flag_d = can_fail_ev | (global_failure_flag_q & !rd_mode);

  // Driver off while stuck, hot or supply low; back as soon as clear
  wire drv_d = !stuck_now && !driver_overtemp && !supply_low;

  wire [3:0] rd_mux =
    (acc_addr == `CFM_ADDR_MODE_CTRL) ? {global_failure_flag_q, 2'b00, can_normal_q} :
    (acc_addr == `CFM_ADDR_CAN_STATUS) ? can_stat_q :
    (acc_addr == `CFM_ADDR_IO_STATUS) ? io_stat_q :
    (acc_addr == `CFM_ADDR_INT_ENABLE) ? int_en_q :
    (acc_addr == `CFM_ADDR_INT_STATUS) ? int_stat_q :
    (acc_addr == `CFM_ADDR_INT_MASK) ? int_mask_q :
    (acc_addr == `CFM_ADDR_CAN_CTRL) ? {3'b000, can_normal_q} : 4'h0;

  // ==========================================================
  // Stuck-dominant timer
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stuck_cnt_q <= '0;
      tx_stuck_q <= 1'b0;
    end
    else
    begin
      if (tx_data)
        stuck_cnt_q <= '0;
      else if (stuck_cnt_q != STUCK_LIM)
        stuck_cnt_q <= stuck_cnt_q + CW'(1);
      tx_stuck_q <= stuck_now;
    end
  end

  // ==========================================================
  // Shifter registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_q <= CFM_SH_IDLE;
      sh_byte_q <= 8'h00;
      sh_cnt_q <= 3'h0;
      sh_out_q <= 4'h0;
      spi_miso_q <= 1'b0;
    end
    else
    begin
      sh_q <= sh_d;
      if (sh_q != CFM_SH_SHIFT)
      begin
        sh_cnt_q <= 3'h0;
        sh_out_q <= can_stat_q;
      end
      else if (spi_sclk_rise)
      begin
        sh_byte_q <= s_next;
        sh_cnt_q <= sh_cnt_q + 3'h1;
        spi_miso_q <= sh_out_q[3];
        sh_out_q <= {sh_out_q[2:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Status and control registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      can_stat_q <= 4'h0;
      io_stat_q <= 4'h0;
      int_en_q <= `CFM_INT_ENABLE_RST;
      int_stat_q <= 4'h0;
      int_mask_q <= `CFM_INT_MASK_RST;
      global_failure_flag_q <= 1'b0;
      can_normal_q <= `CFM_CAN_CTRL_RST;
    end
    else
    begin
      can_stat_q <= can_d;
      io_stat_q <= io_d;
      int_stat_q <= ist_d;
      global_failure_flag_q <= global_failure_flag_d;
      if (wr_ie)
        int_en_q <= acc_wdata;
      if (wr_mask)
        int_mask_q <= acc_wdata;
      if (wr_ctrl)
        can_normal_q <= acc_wdata[`CFM_MODE_CAN_NORMAL_BIT];
    end
  end

  // ==========================================================
  // Output flops
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= 4'h0;
      reset_q <= 1'b1;
      drv_en_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      rdata_q <= reg_rd ? rd_mux : 4'h0;
      reset_q <= !ballast_used && primary_supply_uv;
      drv_en_q <= drv_d;
      irq_q <= |(ist_d & int_mask_q);
    end
  end

  assign reg_rdata = rdata_q;
  assign spi_miso = spi_miso_q;
  assign can_driver_en = drv_en_q;
  assign reset_out = reset_q;
  assign irq = irq_q;

endmodule

// File: bench/cfm_host_model.sv
/*
 Serial host model: shifts one control byte to the monitor, MSB first.
 Assumes core_clk is the monitor's clock and frame holds while busy.
*/
`timescale 1ns/1ps
module cfm_host_model (
  // Clock and request
  input wire logic core_clk,
  input wire logic start,
  input wire logic [7:0] frame,
  // Serial lines
  output logic spi_sel = 1'b0,
  output logic spi_sclk_rise = 1'b0,
  output logic spi_mosi = 1'b0,
  output logic busy = 1'b0
);
  always @(posedge core_clk)
    if (start)
    begin
      busy <= 1'b1;
      spi_sel <= 1'b1;
      for (int i = 7; i >= 0; i--)
      begin
        spi_mosi <= frame[i];
        @(posedge core_clk);
        spi_sclk_rise <= 1'b1;
        @(posedge core_clk);
        spi_sclk_rise <= 1'b0;
      end
      // Released data line shows the inverse of the last bit
      spi_mosi <= ~frame[0];
      @(posedge core_clk);
      spi_sel <= 1'b0;
      busy <= 1'b0;
    end
endmodule

// File: bench/cfm_fault_monitor_props.sv
/*
 Port checker for the fault monitor.
 Assumes it is bound to cfm_fault_monitor, one clock core_clk.
*/
`timescale 1ns/1ps
module cfm_fault_monitor_props #(
  parameter int TX_STUCK_CYC = 20
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Watched ports
  input wire logic reg_rd,
  input wire logic [3:0] reg_rdata,
  input wire logic ballast_used,
  input wire logic secondary_supply_below,
  input wire logic primary_supply_uv,
  input wire logic tx_data,
  input wire logic driver_overtemp,
  input wire logic driver_overcurrent,
  input wire logic can_driver_en,
  input wire logic reset_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic drv_ok;
  int lo_q;
  assign drv_ok = tx_data & ~driver_overtemp & ~driver_overcurrent
    & ~secondary_supply_below & ~primary_supply_uv;
  // Counts cycles of dominant transmit input
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      lo_q <= 0;
    else if (tx_data)
      lo_q <= 0;
    else if (lo_q < TX_STUCK_CYC + 3)
      lo_q <= lo_q + 1;
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 4'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_ot_off;
    driver_overtemp [*2] |-> !can_driver_en;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("driver on in overtemp");
  property p_sup_off;
    (ballast_used && secondary_supply_below) [*2] |-> !can_driver_en;
  endproperty
  a_sup_off: assert property (p_sup_off) else $error("driver on, supply low");
  property p_stuck_off;
    lo_q == TX_STUCK_CYC + 3 |-> !can_driver_en;
  endproperty
  a_stuck_off: assert property (p_stuck_off) else $error("driver on, tx stuck");
  property p_drv_back;
    drv_ok [*3] |-> can_driver_en;
  endproperty
  a_drv_back: assert property (p_drv_back) else $error("driver not restored");
  property p_ot_back;
    $fell(driver_overtemp) ##0 drv_ok [*3] |-> can_driver_en;
  endproperty
  a_ot_back: assert property (p_ot_back) else $error("driver off after cooling");
  property p_rst_on;
    (primary_supply_uv && !ballast_used) [*2] |-> reset_out;
  endproperty
  a_rst_on: assert property (p_rst_on) else $error("reset output missing");
  property p_rst_off;
    !primary_supply_uv [*3] |-> !reset_out;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("reset output stuck");
endmodule

bind cfm_fault_monitor cfm_fault_monitor_props #(.TX_STUCK_CYC(TX_STUCK_CYC)) u_props (
  .core_clk(core_clk), .nrst(nrst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ballast_used(ballast_used), .secondary_supply_below(secondary_supply_below),
  .primary_supply_uv(primary_supply_uv), .tx_data(tx_data),
  .driver_overtemp(driver_overtemp), .driver_overcurrent(driver_overcurrent),
  .can_driver_en(can_driver_en), .reset_out(reset_out));

// File: bench/cfm_fault_monitor_tb.sv
/*
 Self-checking bench for the fault monitor with a serial host model.
 Assumes the port checker is bound from its own file.
*/
`timescale 1ns/1ps
`include "cfm_defines.svh"
module cfm_fault_monitor_tb;
  import cfm_pkg::*;
  logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, start = 0, busy;
  logic [2:0] reg_addr = 0;
  cfm_nib_t reg_wdata = 0, reg_rdata, f = 0, e = 0, d;
  logic [7:0] frame = 0;
  logic spi_sel, spi_sclk_rise, spi_mosi, spi_miso, ballast_used = 1, primary_supply_uv = 0;
  logic tx_data, driver_overtemp, driver_overcurrent, bus_wakeup_event;
  logic secondary_supply_below, switch_overtemp, main_supply_input_low;
  logic can_driver_en, reset_out, irq;
  int fail_count = 0, samples_checked = 0, seed = 20;
  assign bus_wakeup_event = f[0];
  assign driver_overcurrent = f[1] | e[0];
  assign tx_data = ~f[2];
  assign driver_overtemp = f[3];
  assign secondary_supply_below = e[1];
  assign switch_overtemp = e[2];
  assign main_supply_input_low = e[3];
  always #2 core_clk = ~core_clk;
  cfm_fault_monitor #(.TX_STUCK_CYC(20)) u_cfm_fault_monitor (.core_clk, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .spi_sel, .spi_sclk_rise, .spi_mosi, .spi_miso,
    .ballast_used, .secondary_supply_below, .primary_supply_uv, .tx_data, .driver_overtemp,
    .driver_overcurrent, .bus_wakeup_event, .switch_overtemp, .main_supply_input_low,
    .can_driver_en, .reset_out, .irq);
  cfm_host_model u_cfm_host_model (.core_clk, .start, .frame, .spi_sel, .spi_sclk_rise,
    .spi_mosi, .busy);
  // ==========================================================
  // Tasks
  task automatic chk(cfm_nib_t got, cfm_nib_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(logic got, logic exp);
    chk({3'h0, got}, {3'h0, exp});
  endtask
  task automatic bus(logic w, logic [2:0] a, cfm_nib_t v);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(logic [2:0] a, cfm_nib_t exp);
    bus(1'b0, a, 4'h0);
    chk(d, exp);
  endtask
  task automatic wait_irq(logic exp);
    for (int i = 0; i < 6 && irq !== exp; i++)
      @(posedge core_clk);
    #1 chk_pin(irq, exp);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rc(3'h3, `CFM_INT_ENABLE_RST);
    rc(3'h5, `CFM_INT_MASK_RST);
    frame <= {3'h6, 1'b1, 4'h1};
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
      #1 @(posedge core_clk);
    if (busy !== 1'b0)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, busy, 1'b0);
      wrap_up();
    end
    rc(3'h6, 4'h1);
    bus(1'b1, 3'h7, 4'hF);
    rc(3'h7, 4'h0);
    for (int i = 0; i < 8; i++)
    begin
      reg_wdata <= 4'(i == 0 ? 4'hF : $random(seed));
      bus(1'b1, 3'h5, 4'(i == 0 ? 4'hF : $random(seed)));
      rc(3'h5, reg_wdata);
    end
    $display("registers done");
    for (int b = 0; b < 4; b++)
    begin
      f[b] <= 1'b1;
      repeat (30) @(posedge core_clk);
      #1;
      chk_pin(can_driver_en, b < 2);
      chk_pin(irq, 1'b0);
      rc(3'h1, 4'h1 << b);
      rc(3'h1, 4'h1 << b);
      f[b] <= 1'b0;
      repeat (4) @(posedge core_clk);
      rc(3'h1, 4'h1 << b);
      rc(3'h1, 4'h0);
      rc(3'h0, b > 0 ? 4'h9 : 4'h1);
      rc(3'h0, 4'h1);
    end
    $display("faults done");
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, 3'h3, 4'h1 << k);
      bus(1'b1, 3'h5, 4'h0);
      e[k] <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      chk_pin(irq, 1'b0);
      if (k == 1)
        rc(3'h2, 4'h4);
      bus(1'b1, 3'h5, 4'h1 << k);
      wait_irq(1'b1);
      e[k] <= 1'b0;
      repeat (3) @(posedge core_clk);
      rc(3'h4, 4'h1 << k);
      wait_irq(1'b0);
      bus(1'b0, 3'h1, 4'h0);
      bus(1'b0, 3'h0, 4'h0);
    end
    $display("interrupts done");
    ballast_used <= 1'b0;
    primary_supply_uv <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk_pin(reset_out, 1'b1);
    bus(1'b0, 3'h2, 4'h0);
    chk(d & 4'h4, 4'h4);
    primary_supply_uv <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk_pin(reset_out, 1'b0);
    $display("supply done");
    wrap_up();
  end
endmodule
